// [design/touch_adc_pkg.sv]
// Shared constants, command layout and state encodings of the touch ADC serial slave.
package touch_adc_pkg;

	// ==========================================================
	// Address and byte framing
	localparam logic [5:0] ADDR_FIXED     = 6'h24;
	localparam logic [3:0] BYTE_LAST_BIT  = 4'h7;
	localparam logic [3:0] BIT_CNT_RESET  = 4'h0;
	localparam int         RESULT_WIDTH   = 12;

	// ==========================================================
	// Command byte, most significant bit first
	typedef struct packed {
		logic       conv_flag;
		logic [2:0] channel_select;
		logic       ignored_bit_three;
		logic       power_down_select;
		logic       mode_select;
		logic       ignored_bit_zero;
	} command_s;

	localparam command_s COMMAND_RESET = 8'h80;

	// ==========================================================
	// Timing
	localparam real SAMPLE_TIME_US   = 2.5;
	localparam real CLOCK_PERIOD_NS  = 100.0;
	localparam int  SAMPLE_CYCLES    = int'($ceil(SAMPLE_TIME_US * 1000.0 / CLOCK_PERIOD_NS));
	localparam int  SAMPLE_CNT_WIDTH = 8;

	// ==========================================================
	// State encodings
	typedef enum logic [7:0] {
		LK_IDLE     = 8'h01,
		LK_ADDR     = 8'h02,
		LK_ADDR_ACK = 8'h04,
		LK_CMD      = 8'h08,
		LK_CMD_ACK  = 8'h10,
		LK_TX       = 8'h20,
		LK_TX_ACK   = 8'h40,
		LK_IGNORE   = 8'h80
	} link_state_e;

	typedef enum logic [2:0] {
		CV_IDLE    = 3'h1,
		CV_SAMPLE  = 3'h2,
		CV_CONVERT = 3'h4
	} conv_state_e;

endpackage

// [design/touch_adc_sequencer.sv]
// Sampling and conversion sequencer for the touch ADC.
`timescale 1ns/10ps
module touch_adc_sequencer #(
	parameter int SAMPLE_CYCLES = touch_adc_pkg::SAMPLE_CYCLES,
	parameter int RESULT_WIDTH  = touch_adc_pkg::RESULT_WIDTH
) (
	input  wire logic                    clock_in,
	input  wire logic                    sys_rst_in,
	input  wire logic                    ce_in,
	input  wire logic                    start_in,
	input  wire logic                    adc_done_in,
	input  wire logic [RESULT_WIDTH-1:0] adc_result_in,
	output logic                         sample_out,
	output logic                         convert_out,
	output logic [RESULT_WIDTH-1:0]      result_out,
	output logic                         result_tog_out
);

	localparam logic [touch_adc_pkg::SAMPLE_CNT_WIDTH-1:0] SAMPLE_LAST =
		touch_adc_pkg::SAMPLE_CNT_WIDTH'(SAMPLE_CYCLES - 1);

	touch_adc_pkg::conv_state_e                  state;
	logic [touch_adc_pkg::SAMPLE_CNT_WIDTH-1:0]  sample_cnt;

	// ==========================================================
	// Sequencer
	// minimum sampling time
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state          <= touch_adc_pkg::CV_IDLE;
			sample_cnt     <= '0;
			sample_out     <= 1'b0;
			convert_out    <= 1'b0;
			result_out     <= '0;
			result_tog_out <= 1'b0;
		end else if (ce_in) begin
			case (state)
				touch_adc_pkg::CV_IDLE: begin
					if (start_in) begin
						state      <= touch_adc_pkg::CV_SAMPLE;
						sample_cnt <= '0;
						sample_out <= 1'b1;
					end
				end
				touch_adc_pkg::CV_SAMPLE: begin
					sample_cnt <= sample_cnt + 1'b1;
					if (sample_cnt == SAMPLE_LAST) begin
						state       <= touch_adc_pkg::CV_CONVERT;
						sample_out  <= 1'b0;
						convert_out <= 1'b1;
					end
				end
				touch_adc_pkg::CV_CONVERT: begin
					if (adc_done_in) begin
						state          <= touch_adc_pkg::CV_IDLE;
						convert_out    <= 1'b0;
						result_out     <= adc_result_in;
						result_tog_out <= ~result_tog_out;
					end
				end
				default: begin
					state       <= touch_adc_pkg::CV_IDLE;
					sample_out  <= 1'b0;
					convert_out <= 1'b0;
				end
			endcase
		end
	end

	property p_sample_len;
		@(posedge clock_in) disable iff (sys_rst_in)
		$fell(sample_out) |-> ($past(sample_cnt) == SAMPLE_LAST);
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sampling phase too short");

endmodule // touch_adc_sequencer

// [design/touch_adc_serial_slave.sv]
// Two-wire serial slave port and command logic of the touch-screen controller.
`timescale 1ns/10ps

// Function
// - Works at 100 kHz and 400 kHz bus clocks; 3.4 MHz is not supported.
// - Slave only: never drives the clock, START or STOP.
// - SDA fall with SCL high is START; SDA rise with SCL high is STOP.
// - Transfers end with STOP or repeated START; repeated START opens the next one.
// - SDA changes only while SCL is low, except START and STOP.
// - Device holds SDA low through the acknowledge pulse after each received byte.
// - Transmitter releases SDA after eight bits; ack continues, not-ack stops.
// - Upper six address bits must equal 100100.
// - Seventh address bit is compared with the address select pin.
// - Address LSB 1 means read, 0 means write.
// - Matching address byte is acknowledged by pulling SDA low.
// - Byte after a write address is the 8-bit command, MSB first.
// - Command: D7 flag, D6-D4 channel, D2 power-down, D1 resolution, D3 and D0 ignored.
// - Last written command is kept and governs every later read.
// - Each read starts a new conversion; after a sleep command a read starts none.
// - Results MSB first; 8-bit gives one byte, 12-bit two bytes padded with zeros.
// - 12-bit read: upper byte, master ack, lower nibble plus zeros, master not-ack.
// - Channel bits of the last command choose the measured quantity.
// - Sampling lasts at least 2.5 us before conversion.
// - Flag 1 is a conversion command, flag 0 a sleep command.
// - With flag 1, resolution bit 0 is 12-bit, 1 is 8-bit; else sleep variant.
// - Sleep entry or exit takes effect at the 16th SCL rising edge; the command is taken at the 17th (here sleep_out changes only after the 17th).
// - Power-down bit chooses auto power-down with pen interrupt, or always on without.
module touch_adc_serial_slave #(
	parameter int SAMPLE_CYCLES = touch_adc_pkg::SAMPLE_CYCLES
) (
	input  wire logic                                   clock_in,
	input  wire logic                                   sys_rst_in,
	input  wire logic                                   ce_in,
	input  wire logic                                   scl_in,
	input  wire logic                                   sda_in,
	input  wire logic                                   device_address_select_in,
	input  wire logic                                   adc_done_in,
	input  wire logic [touch_adc_pkg::RESULT_WIDTH-1:0] adc_result_in,
	output logic                                        sda_out,
	output logic                                        sda_oe_out,
	output logic [2:0]                                  channel_select_out,
	output logic                                        power_down_select_out,
	output logic                                        resolution_8bit_out,
	output logic                                        sleep_out,
	output logic                                        sleep_variant_out,
	output logic                                        adc_power_out,
	output logic                                        pen_irq_enable_out,
	output logic                                        sample_out,
	output logic                                        convert_out
);

	localparam int RW = touch_adc_pkg::RESULT_WIDTH;
	localparam logic [3:0] BYTE_LAST = touch_adc_pkg::BYTE_LAST_BIT;
	// Link domain.
	touch_adc_pkg::link_state_e state;
	touch_adc_pkg::command_s    cmd_link;
	logic                       start_tog;
	logic                       stop_tog;
	logic                       start_seen;
	logic                       stop_seen;
	logic                       frame_start;
	logic                       frame_stop;
	logic                       device_address_select_meta;
	logic                       device_address_select_sync;
	logic [3:0]                 bit_cnt;
	logic [7:0]                 shift_q;
	logic [7:0]                 tx_byte;
	logic                       second_byte;
	logic                       cmd_tog;
	logic                       conv_tog;
	logic                       res_meta;
	logic                       res_sync;
	logic                       res_seen;
	logic [RW-1:0]              res_link;
	logic [RW-1:0]              tx_res;
	logic                       oe_link;
	logic                       addr_ok;

	// System domain.
	touch_adc_pkg::command_s    touch_command;
	logic [2:0]                 cmd_sync;
	logic [2:0]                 conv_sync;
	logic                       oe_meta;
	logic                       conv_go;
	logic [RW-1:0]              seq_result;
	logic                       seq_tog;

	assign frame_start = start_tog != start_seen;
	assign frame_stop  = stop_tog != stop_seen;
	assign addr_ok     = (shift_q[6:1] == touch_adc_pkg::ADDR_FIXED) && (shift_q[0] == device_address_select_sync);

	// ==========================================================
	// Bus condition detection
	// The bus clock stands still between frames, so START and STOP are caught on SDA edges
	// and the link logic uses an asynchronous reset that needs no bus clock edge.
	// START and STOP detection
	always_ff @(negedge sda_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			start_tog <= 1'b0;
		end else if (scl_in) begin
			start_tog <= ~start_tog;
		end
	end
	always_ff @(posedge sda_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stop_tog <= 1'b0;
		end else if (scl_in) begin
			stop_tog <= ~stop_tog;
		end
	end

	// ==========================================================
	// Link synchronisers
	always_ff @(posedge scl_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			device_address_select_meta <= 1'b0;
			device_address_select_sync <= 1'b0;
			res_meta  <= 1'b0;
			res_sync  <= 1'b0;
			res_seen  <= 1'b0;
			res_link  <= '0;
		end else begin
			device_address_select_meta <= device_address_select_in;
			device_address_select_sync <= device_address_select_meta;
			res_meta  <= seq_tog;
			res_sync  <= res_meta;
			res_seen  <= res_sync;
			if (res_sync != res_seen) begin
				res_link <= seq_result;
			end
		end
	end

	// ==========================================================
	// Link protocol engine, sampled on SCL rising edges
	always_ff @(posedge scl_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state       <= touch_adc_pkg::LK_IDLE;
			start_seen  <= 1'b0;
			stop_seen   <= 1'b0;
			bit_cnt     <= touch_adc_pkg::BIT_CNT_RESET;
			shift_q     <= '0;
			tx_byte     <= '0;
			tx_res      <= '0;
			second_byte <= 1'b0;
			cmd_link    <= touch_adc_pkg::COMMAND_RESET;
			cmd_tog     <= 1'b0;
			conv_tog    <= 1'b0;
		end else begin
			start_seen <= start_tog;
			stop_seen  <= stop_tog;
			// START and repeated START open a frame
			// START or STOP closes the previous one
			if (frame_start) begin
				state   <= touch_adc_pkg::LK_ADDR;
				shift_q <= {7'h00, sda_in};
				bit_cnt <= 4'h1;
			end else if (frame_stop) begin
				state <= touch_adc_pkg::LK_IDLE;
			end else begin
				case (state)
					touch_adc_pkg::LK_ADDR: begin
						shift_q <= {shift_q[6:0], sda_in};
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == BYTE_LAST) begin
							state <= addr_ok ? touch_adc_pkg::LK_ADDR_ACK
									 : touch_adc_pkg::LK_IGNORE;
						end
					end
					touch_adc_pkg::LK_ADDR_ACK: begin
						bit_cnt     <= touch_adc_pkg::BIT_CNT_RESET;
						second_byte <= 1'b0;
						if (shift_q[0]) begin
							state <= touch_adc_pkg::LK_TX;
							tx_byte <= res_link[RW-1 -: 8];
							// The whole result is held so both bytes of one read belong together.
							tx_res  <= res_link;
							conv_tog <= ~conv_tog;
						end else begin
							state <= touch_adc_pkg::LK_CMD;
						end
					end
					touch_adc_pkg::LK_CMD: begin
						shift_q <= {shift_q[6:0], sda_in};
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == BYTE_LAST) begin
							// taken at the 17th rising edge
							cmd_link <= touch_adc_pkg::command_s'({shift_q[6:0], sda_in});
							cmd_tog  <= ~cmd_tog;
							state    <= touch_adc_pkg::LK_CMD_ACK;
						end
					end
					touch_adc_pkg::LK_CMD_ACK: begin
						bit_cnt <= touch_adc_pkg::BIT_CNT_RESET;
						state   <= touch_adc_pkg::LK_CMD;
					end
					touch_adc_pkg::LK_TX: begin
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == BYTE_LAST) begin
							state <= touch_adc_pkg::LK_TX_ACK;
						end
					end
					touch_adc_pkg::LK_TX_ACK: begin
						bit_cnt <= touch_adc_pkg::BIT_CNT_RESET;
						if (sda_in) begin
							state <= touch_adc_pkg::LK_IGNORE;
						end else if (!second_byte && !cmd_link.mode_select) begin
							state       <= touch_adc_pkg::LK_TX;
							second_byte <= 1'b1;
							tx_byte     <= {tx_res[3:0], 4'h0};
						end else begin
							state       <= touch_adc_pkg::LK_TX;
							second_byte <= 1'b0;
							tx_byte     <= tx_res[RW-1 -: 8];
						end
					end
					touch_adc_pkg::LK_IDLE,
					touch_adc_pkg::LK_IGNORE: state <= state;
					default: state <= touch_adc_pkg::LK_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// SDA drive, prepared on SCL falling edges
	always_ff @(negedge scl_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			oe_link <= 1'b0;
		end else if (frame_start || frame_stop) begin
			oe_link <= 1'b0;
		end else begin
			case (state)
				// hold low through the acknowledge pulse
				touch_adc_pkg::LK_ADDR_ACK,
				touch_adc_pkg::LK_CMD_ACK: oe_link <= 1'b1;
				// data changes only while SCL is low
				touch_adc_pkg::LK_TX:      oe_link <= ~tx_byte[3'(BYTE_LAST - bit_cnt)];
				default:                   oe_link <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Crossings into the system clock
	// settles within the low phase
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cmd_sync   <= '0;
			conv_sync  <= '0;
			oe_meta    <= 1'b0;
			sda_oe_out <= 1'b0;
			sda_out    <= 1'b0;
		end else if (ce_in) begin
			cmd_sync   <= {cmd_sync[1:0], cmd_tog};
			conv_sync  <= {conv_sync[1:0], conv_tog};
			oe_meta    <= oe_link;
			sda_oe_out <= oe_meta;
			sda_out    <= 1'b0;
		end
	end

	// ==========================================================
	// Command register and mode control
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			touch_command     <= touch_adc_pkg::COMMAND_RESET;
			sleep_out         <= 1'b0;
			sleep_variant_out <= 1'b0;
			conv_go           <= 1'b0;
		end else if (ce_in) begin
			conv_go <= 1'b0;
			if (cmd_sync[2] != cmd_sync[1]) begin
				touch_command <= cmd_link;
				sleep_out <= !cmd_link.conv_flag;
				// resolution bit doubles as sleep variant
				sleep_variant_out <= cmd_link.conv_flag ? sleep_variant_out : cmd_link.mode_select;
				conv_go <= cmd_link.conv_flag;
			end else if (conv_sync[2] != conv_sync[1]) begin
				conv_go <= touch_command.conv_flag && !sleep_out;
			end
		end
	end

	// ==========================================================
	// Outputs to the analog side
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			channel_select_out    <= touch_adc_pkg::COMMAND_RESET.channel_select;
			power_down_select_out <= 1'b0;
			resolution_8bit_out   <= 1'b0;
			adc_power_out         <= 1'b0;
			pen_irq_enable_out    <= 1'b0;
		end else if (ce_in) begin
			channel_select_out    <= touch_command.channel_select;
			power_down_select_out <= touch_command.power_down_select;
			resolution_8bit_out   <= touch_command.mode_select;
			adc_power_out      <= (touch_command.power_down_select && !sleep_out)
					      || sample_out || convert_out || conv_go;
			pen_irq_enable_out <= !touch_command.power_down_select && !sleep_out
					      && !sample_out && !convert_out && !conv_go;
		end
	end

	touch_adc_sequencer #(
		.SAMPLE_CYCLES (SAMPLE_CYCLES),
		.RESULT_WIDTH  (RW)
	) sequencer (
		.clock_in       (clock_in),
		.sys_rst_in     (sys_rst_in),
		.ce_in          (ce_in),
		.start_in       (conv_go),
		.adc_done_in    (adc_done_in),
		.adc_result_in  (adc_result_in),
		.sample_out     (sample_out),
		.convert_out    (convert_out),
		.result_out     (seq_result),
		.result_tog_out (seq_tog)
	);

	// ==========================================================
	// Checks
	property p_addr_match;
		@(posedge scl_in) disable iff (sys_rst_in)
		(state == touch_adc_pkg::LK_ADDR && bit_cnt == 4'h7 && addr_ok
		 && !frame_start && !frame_stop) |=> (state == touch_adc_pkg::LK_ADDR_ACK);
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("matching address not taken");
	property p_addr_miss;
		@(posedge scl_in) disable iff (sys_rst_in)
		(state == touch_adc_pkg::LK_ADDR && bit_cnt == 4'h7 && !addr_ok
		 && !frame_start && !frame_stop) |=> (state == touch_adc_pkg::LK_IGNORE);
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address not ignored");
	property p_ack_drive;
		@(posedge scl_in) disable iff (sys_rst_in)
		(state == touch_adc_pkg::LK_CMD_ACK || state == touch_adc_pkg::LK_ADDR_ACK)
		&& !frame_start && !frame_stop |-> oe_link;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");
	property p_tx_release;
		@(posedge scl_in) disable iff (sys_rst_in)
		(state == touch_adc_pkg::LK_TX_ACK) |-> !oe_link;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("SDA held in ack slot");
	property p_read_conv;
		@(posedge scl_in) disable iff (sys_rst_in)
		(state == touch_adc_pkg::LK_ADDR_ACK && shift_q[0] && !frame_start && !frame_stop)
		|=> (conv_tog != $past(conv_tog)) && (state == touch_adc_pkg::LK_TX);
	endproperty
	a_read_conv: assert property (p_read_conv) else $error("read did not start conversion");
	property p_second_byte;
		@(posedge scl_in) disable iff (sys_rst_in)
		(state == touch_adc_pkg::LK_TX_ACK && !sda_in && !second_byte
		 && !cmd_link.mode_select && !frame_start && !frame_stop)
		|=> (tx_byte == {tx_res[3:0], 4'h0}) ##8 (state == touch_adc_pkg::LK_TX_ACK);
	endproperty
	a_second_byte: assert property (p_second_byte) else $error("lower result byte wrong");
	property p_sleep_entry;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && cmd_sync[2] != cmd_sync[1] && !cmd_link.conv_flag)
		|=> sleep_out && (touch_command == $past(cmd_link));
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep command not applied");
	property p_cmd_outputs;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && cmd_sync[2] != cmd_sync[1]) ##1 ce_in
		|=> (channel_select_out == $past(touch_command.channel_select, 1))
		 && (resolution_8bit_out == $past(touch_command.mode_select, 1));
	endproperty
	a_cmd_outputs: assert property (p_cmd_outputs) else $error("command fields not applied");
	property p_pen_disable;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && touch_command.power_down_select) |=> !pen_irq_enable_out;
	endproperty
	a_pen_disable: assert property (p_pen_disable) else $error("pen interrupt left enabled");

endmodule // touch_adc_serial_slave

// [sim/i2c_master_model.sv]
// Two-wire bus master model that drives the slave port from the far side.
`timescale 1ns/10ps
module i2c_master_model (
	input  wire logic clk_in,
	input  wire logic dev_oe_in,
	output logic      scl_out,
	output logic      sda_out
);
	localparam int HALF = 13;
	logic sda_m = 1'b1;
	initial scl_out = 1'b1;
	// pull-up wins unless a party pulls low.
	assign sda_out = sda_m & ~dev_oe_in;
	task automatic hold(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// START, also used as repeated START.
	task automatic start();
		sda_m = 1'b1;
		hold(4);
		scl_out = 1'b1;
		hold(HALF);
		sda_m = 1'b0;
		hold(HALF);
		scl_out = 1'b0;
	endtask
	// data moves only in the low phase.
	task automatic xfer(input logic b, output logic got);
		hold(4);
		sda_m = b;
		hold(HALF - 4);
		scl_out = 1'b1;
		hold(6);
		got = sda_out;
		hold(HALF - 6);
		scl_out = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
			output logic ack);
		for (int i = 7; i >= 0; i--)
			xfer(d[i], q[i]);
		xfer(ack_in, ack);
	endtask
	task automatic stop();
		hold(4);
		sda_m = 1'b0;
		hold(HALF);
		scl_out = 1'b1;
		hold(HALF);
		sda_m = 1'b1;
		hold(HALF);
	endtask
endmodule // i2c_master_model

// [sim/tb.sv]
// Self-checking testbench of the touch ADC serial slave port.
`timescale 1ns/10ps
module tb;
	logic        clock_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        strap = 1'b0;
	logic        adc_done = 1'b0;
	logic [11:0] adc_res = 12'h000;
	logic [11:0] last_res = 12'h000;
	logic        scl, sda, sda_oe, sda_o, pd, res8, slp, slp_var, sample, convert, pwr, pen;
	logic [2:0]  chan;
	int          bad_count = 0;
	int          n_compared = 0;
	int          n_conv = 0;
	int          run_len = 0;
	int          min_run = 1000;

	always #50 clock_in = ~clock_in;

	touch_adc_serial_slave i_touch_adc_serial_slave (.clock_in(clock_in),
		.sys_rst_in(sys_rst_in), .ce_in(1'b1), .scl_in(scl), .sda_in(sda),
		.device_address_select_in(strap), .adc_done_in(adc_done), .adc_result_in(adc_res),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .channel_select_out(chan),
		.power_down_select_out(pd), .resolution_8bit_out(res8), .sleep_out(slp),
		.sleep_variant_out(slp_var), .adc_power_out(pwr), .pen_irq_enable_out(pen),
		.sample_out(sample), .convert_out(convert));
	i2c_master_model i_i2c_master_model (.clk_in(clock_in), .dev_oe_in(sda_oe),
		.scl_out(scl), .sda_out(sda));

	// ==========================================================
	// Converter stand-in; it answers one cycle into each conversion.
	always @(negedge clock_in) begin
		adc_done <= convert & ~adc_done;
		if (convert & ~adc_done)
			last_res <= adc_res;
		if (~convert)
			adc_res <= 12'($urandom);
		run_len <= sample ? run_len + 1 : 0;
		if (!sample && run_len > 0 && run_len < min_run)
			min_run <= run_len;
	end
	always @(posedge convert) n_conv++;

	// ==========================================================
	// Checks and bus sequences
	task automatic fail(input string m);
		bad_count++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk_b(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
			fail("flag mismatch");
	endtask
	task automatic chk_v(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp)
			fail("value mismatch");
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr_cmd(input logic [7:0] cmd, input logic [6:0] addr, input logic ackd);
		logic [7:0] q;
		logic a;
		i_i2c_master_model.start();
		i_i2c_master_model.byte_io({addr, 1'b0}, 1'b1, q, a);
		chk_b(a, ~ackd);
		i_i2c_master_model.byte_io(cmd, 1'b1, q, a);
		chk_b(a, ~ackd);
	endtask
	task automatic rd(input int n, output logic [7:0] b0, output logic [7:0] b1);
		logic a;
		i_i2c_master_model.start();
		i_i2c_master_model.byte_io({touch_adc_pkg::ADDR_FIXED, strap, 1'b1}, 1'b1, b0, a);
		chk_b(a, 1'b0);
		i_i2c_master_model.byte_io(8'hFF, n == 1, b0, a);
		if (n > 1)
			i_i2c_master_model.byte_io(8'hFF, 1'b1, b1, a);
		i_i2c_master_model.stop();
	endtask

	initial begin
		#5ms;
		fail("timeout");
		give_verdict();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] cmd, b0, b1;
		logic [11:0] exp;
		int c0;
		void'($urandom(32'hC519));
		strap = 1'($urandom);
		repeat (3) @(negedge clock_in);
		sys_rst_in = 1'b0;
		@(negedge clock_in);
		chk_v({6'h00, sda_oe, chan, res8, slp}, 12'h000);
		wr_cmd(8'hD2, {touch_adc_pkg::ADDR_FIXED, ~strap}, 1'b0);
		i_i2c_master_model.stop();
		wr_cmd(8'hD2, {touch_adc_pkg::ADDR_FIXED ^ 6'h01, strap}, 1'b0);
		i_i2c_master_model.stop();
		chk_v({8'h00, chan, res8}, 12'h000);
		$display("test foreign address done");
		for (int ch = 0; ch < 8; ch++) begin
			cmd = {1'b1, 3'(ch), 1'($urandom), 1'($urandom), 1'b0, 1'($urandom)};
			wr_cmd(cmd, {touch_adc_pkg::ADDR_FIXED, strap}, 1'b1);
			i_i2c_master_model.stop();
			chk_v({7'h00, chan, pd, res8}, {7'h00, cmd[6:4], cmd[2], 1'b0});
			chk_v({10'h000, pen, pwr}, {10'h000, ~cmd[2], cmd[2]});
			repeat (2) begin
				exp = last_res;
				c0 = n_conv;
				rd(2, b0, b1);
				chk_v({b0, b1[7:4]}, exp);
				chk_v({8'h00, b1[3:0]}, 12'h000);
				chk_v(12'(n_conv - c0), 12'h001);
			end
		end
		chk_b(min_run >= touch_adc_pkg::SAMPLE_CYCLES, 1'b1);
		$display("test twelve-bit reads done");
		wr_cmd(8'hD2, {touch_adc_pkg::ADDR_FIXED, strap}, 1'b1);
		i_i2c_master_model.stop();
		chk_b(res8, 1'b1);
		exp = last_res;
		rd(2, b0, b1);
		chk_v({b0, b1[7:4]}, {exp[11:4], exp[11:8]});
		$display("test eight-bit read done");
		for (int m = 0; m < 2; m++) begin
			c0 = n_conv;
			cmd = {4'h7, 1'($urandom), 1'($urandom), 1'(m), 1'($urandom)};
			wr_cmd(cmd, {touch_adc_pkg::ADDR_FIXED, strap}, 1'b1);
			rd(1, b0, b1);
			chk_v({7'h00, pen, pwr, slp, slp_var, sda_o}, {7'h00, 2'h0, 1'b1, 1'(m), 1'b0});
			chk_v(12'(n_conv - c0), 12'h000);
		end
		wr_cmd(8'h80, {touch_adc_pkg::ADDR_FIXED, strap}, 1'b1);
		i_i2c_master_model.stop();
		chk_b(slp, 1'b0);
		$display("test sleep done");
		give_verdict();
	end
endmodule // tb
